// *** rtl/lapm_pkg.sv ***
// Overview of operation
// - PID compensator coefficients reconfigurable by host
// - Tune after ramp-up, apply new coefficients
// - Tuning run completes in 50 to 200 ms
// - Four modes: off, each enable, second, minute
// - Once-only option reuses held result until repower
// - Host trigger command starts tuning run
// - Gain scales result, 10 to 100 percent
// - Working settings filled strap, factory, user order
// - Tuning on at power-up loads safe default
// - Tuned result written to working, used immediately
// - User store saves all working settings
// - Off to on loads safe default
// - On to off reloads user coefficients
// - Tuning off at power-up loads user coefficients
// - All loop settings reachable by host
package lapm_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned TUNE_MIN_MS = 50;
  localparam int unsigned TUNE_MAX_MS = 200;
  localparam int unsigned PERIOD_SEC_MS = 1000;
  localparam int unsigned TUNE_MIN_CYC = TUNE_MIN_MS * CYC_PER_MS;
  localparam int unsigned TUNE_MAX_CYC = TUNE_MAX_MS * CYC_PER_MS;
  localparam int unsigned SEC_CYC = PERIOD_SEC_MS * CYC_PER_MS;
  localparam logic [5:0] SEC_PER_MIN = 6'h3c;

  // ==========================================================
  // Coefficient and gain layout
  localparam int unsigned COEF_W = 72;
  localparam int unsigned TAP_W = 24;
  localparam int unsigned NUM_TAPS = 3;
  localparam int unsigned GAIN_W = 7;
  localparam logic [GAIN_W-1:0] GAIN_FULL = 7'h64;
  localparam logic [GAIN_W-1:0] GAIN_MIN = 7'h0a;
  localparam logic [GAIN_W-1:0] GAIN_RST = 7'h32;
  localparam logic [COEF_W-1:0] SAFE_COEF = 72'h000400_fff800_000400;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_EACH_ENABLE = 2'h1,
    MODE_EVERY_SEC = 2'h2,
    MODE_EVERY_MIN = 2'h3
  } lapm_mode_t;
  localparam lapm_mode_t MODE_RST = MODE_EACH_ENABLE;

  typedef enum logic [3:0] {
    INIT_STRAP = 4'h1,
    INIT_FACTORY = 4'h2,
    INIT_USER = 4'h4,
    INIT_RUN = 4'h8
  } lapm_init_t;

  typedef enum logic [2:0] {
    TUNE_IDLE = 3'h1,
    TUNE_MEAS = 3'h2,
    TUNE_APPLY = 3'h4
  } lapm_tune_t;

  // ==========================================================
  // Helpers
  function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] g);
    if (g < GAIN_MIN) begin
      return GAIN_MIN;
    end
    if (g > GAIN_FULL) begin
      return GAIN_FULL;
    end
    return g;
  endfunction

  function automatic logic [COEF_W-1:0] scale_coef(input logic [COEF_W-1:0] c,
                                                 input logic [GAIN_W-1:0] g);
    logic signed [TAP_W+GAIN_W:0] prod;
    logic [COEF_W-1:0] r;
    r = '0;
    prod = '0;
    for (int i = 0; i < NUM_TAPS; i++) begin
      prod = $signed(c[i*TAP_W +: TAP_W]) * $signed({1'b0, g});
      prod = prod / $signed({1'b0, GAIN_FULL});
      r[i*TAP_W +: TAP_W] = prod[TAP_W-1:0];
    end
    return r;
  endfunction

  function automatic logic mode_on(input lapm_mode_t m);
    return m != MODE_OFF;
  endfunction

endpackage

// *** rtl/lapm_tune_if.sv ***
`timescale 1ns/10ps
interface lapm_tune_if;
  import lapm_pkg::*;
  logic start;
  logic [GAIN_W-1:0] gain;
  logic busy;
  logic done;
  logic ok;
  logic [COEF_W-1:0] result;
  modport ctrl (output start, output gain, input busy, input done, input ok, input result);
  modport eng (input start, input gain, output busy, output done, output ok, output result);
endinterface

// *** rtl/lapm_timer.sv ***
`timescale 1ns/10ps
module lapm_timer
  import lapm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic per_min,
  // Event
  output logic tick
);
  localparam int unsigned SW = $clog2(SEC_CYCLES + 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(SEC_CYCLES - 1);

  logic [SW-1:0] sec_reg, sec_next;
  logic [5:0] min_reg, min_next;
  logic tick_reg, tick_next;

  // ==========================================================
  // Periodic boundary counter
  always_comb begin
    sec_next = sec_reg;
    min_next = min_reg;
    tick_next = 1'b0;
    if (!run) begin
      sec_next = '0;
      min_next = '0;
    end else if (sec_reg == SEC_LAST) begin
      sec_next = '0;
      if (!per_min || min_reg == SEC_PER_MIN - 6'h01) begin
        min_next = '0;
        tick_next = 1'b1;
      end else begin
        min_next = min_reg + 6'h01;
      end
    end else begin
      sec_next = sec_reg + SW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sec_reg <= '0;
      min_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// *** rtl/lapm_tuner.sv ***
`timescale 1ns/10ps
module lapm_tuner
  import lapm_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = TUNE_MIN_CYC,
  parameter int unsigned MAX_CYCLES = TUNE_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Power-train measurement
  input wire logic meas_valid,
  input wire logic [COEF_W-1:0] meas_coef,
  // Controller side
  lapm_tune_if.eng tif
);
  localparam int unsigned CW = $clog2(MAX_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MIN = CW'(MIN_CYCLES - 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MAX_CYCLES - 1);

  lapm_tune_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic have_reg, have_next;
  logic ok_reg, ok_next;
  logic [GAIN_W-1:0] gain_reg, gain_next;
  logic [COEF_W-1:0] cap_reg, cap_next;
  logic [COEF_W-1:0] res_reg, res_next;

  // ==========================================================
  // Tuning run sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    have_next = have_reg;
    ok_next = ok_reg;
    gain_next = gain_reg;
    cap_next = cap_reg;
    res_next = res_reg;
    unique case (st_reg)
      TUNE_IDLE: begin
        if (tif.start) begin
          st_next = TUNE_MEAS;
          cnt_next = '0;
          have_next = 1'b0;
          gain_next = clamp_gain(tif.gain);
        end
      end
      TUNE_MEAS: begin
        cnt_next = cnt_reg + CW'(1);
        if (meas_valid && !have_reg) begin
          have_next = 1'b1;
          cap_next = meas_coef;
        end
        if ((have_reg || meas_valid) && cnt_reg >= CNT_MIN) begin
          st_next = TUNE_APPLY;
          ok_next = 1'b1;
          res_next = scale_coef(have_reg ? cap_reg : meas_coef, gain_reg);
        end else if (cnt_reg >= CNT_MAX) begin
          st_next = TUNE_APPLY;
          ok_next = 1'b0;
        end
      end
      TUNE_APPLY: begin
        st_next = TUNE_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= TUNE_IDLE;
      cnt_reg <= '0;
      have_reg <= 1'b0;
      ok_reg <= 1'b0;
      gain_reg <= GAIN_RST;
      cap_reg <= '0;
      res_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      have_reg <= have_next;
      ok_reg <= ok_next;
      gain_reg <= gain_next;
      cap_reg <= cap_next;
      res_reg <= res_next;
    end
  end

  assign tif.busy = st_reg != TUNE_IDLE;
  assign tif.done = st_reg == TUNE_APPLY;
  assign tif.ok = ok_reg;
  assign tif.result = res_reg;
endmodule

// *** rtl/lapm_top.sv ***
`timescale 1ns/10ps
module lapm_top
  import lapm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC,
  parameter int unsigned TUNE_MIN_CYCLES = TUNE_MIN_CYC,
  parameter int unsigned TUNE_MAX_CYCLES = TUNE_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Host commands
  input wire logic host_coef_wr,
  input wire logic [COEF_W-1:0] host_coef_data,
  input wire logic host_mode_wr,
  input wire lapm_mode_t host_mode,
  input wire logic host_once_wr,
  input wire logic host_once,
  input wire logic host_gain_wr,
  input wire logic [GAIN_W-1:0] host_gain,
  input wire logic host_tune_trig,
  input wire logic host_store_user,
  // Pin strap
  input wire logic strap_tune_off,
  // Factory store contents
  input wire logic factory_valid,
  input wire lapm_mode_t factory_mode,
  input wire logic [GAIN_W-1:0] factory_gain,
  input wire logic [COEF_W-1:0] factory_coef,
  // User store contents
  input wire logic user_valid,
  input wire lapm_mode_t user_mode,
  input wire logic user_once,
  input wire logic [GAIN_W-1:0] user_gain,
  input wire logic [COEF_W-1:0] user_coef,
  // Power train
  input wire logic output_en,
  input wire logic ramp_done,
  input wire logic meas_valid,
  input wire logic [COEF_W-1:0] meas_coef,
  // Working settings
  output logic [COEF_W-1:0] coef_out,
  output lapm_mode_t mode_out,
  output logic once_out,
  output logic [GAIN_W-1:0] gain_out,
  // Status
  output logic init_done,
  output logic tune_busy,
  output logic tune_done,
  // User store write
  output logic store_stb,
  output lapm_mode_t store_mode,
  output logic store_once,
  output logic [GAIN_W-1:0] store_gain,
  output logic [COEF_W-1:0] store_coef
);

  lapm_tune_if tif ();

  // ==========================================================
  // Strap synchroniser and edge detect
  logic strap_s1_reg, strap_s2_reg;
  logic ramp_q_reg, oe_q_reg;
  logic ramp_rise, oe_rise, tick;

  // Strap stages run through reset so the pin is settled at release
  always_ff @(posedge ref_clk) begin
    strap_s1_reg <= strap_tune_off;
    strap_s2_reg <= strap_s1_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ramp_q_reg <= 1'b0;
      oe_q_reg <= 1'b0;
    end else begin
      ramp_q_reg <= ramp_done;
      oe_q_reg <= output_en;
    end
  end

  assign ramp_rise = ramp_done && !ramp_q_reg;
  assign oe_rise = output_en && !oe_q_reg;

  // ==========================================================
  // Working settings state
  lapm_init_t st_reg, st_next;
  logic init_reg, init_next;
  lapm_mode_t mode_reg, mode_next;
  lapm_mode_t act_reg, act_next;
  logic once_reg, once_next;
  logic [GAIN_W-1:0] gain_reg, gain_next;
  logic [COEF_W-1:0] coef_reg, coef_next;
  logic [COEF_W-1:0] ucoef_reg, ucoef_next;
  logic [COEF_W-1:0] held_reg, held_next;
  logic held_ok_reg, held_ok_next;
  logic en_prev_reg, en_prev_next;
  logic busy_reg, done_reg;
  logic stb_reg, stb_next;
  lapm_mode_t smode_reg, smode_next;
  logic sonce_reg, sonce_next;
  logic [GAIN_W-1:0] sgain_reg, sgain_next;
  logic [COEF_W-1:0] scoef_reg, scoef_next;
  logic running, periodic, reuse, start_req;
  lapm_mode_t fin_mode;

  assign running = st_reg == INIT_RUN;
  assign periodic = act_reg == MODE_EVERY_SEC || act_reg == MODE_EVERY_MIN;
  assign reuse = once_reg && held_ok_reg;
  assign start_req = host_tune_trig || tick ||
                     (ramp_rise && act_reg == MODE_EACH_ENABLE && !reuse);
  assign tif.start = running && start_req && !tif.busy;
  assign tif.gain = gain_reg;
  assign fin_mode = user_valid ? user_mode : mode_reg;

  lapm_timer #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .run(running && output_en && periodic),
    .per_min(act_reg == MODE_EVERY_MIN),
    .tick(tick)
  );

  lapm_tuner #(
    .MIN_CYCLES(TUNE_MIN_CYCLES),
    .MAX_CYCLES(TUNE_MAX_CYCLES)
  ) u_tuner (
    .ref_clk(ref_clk),
    .srst(srst),
    .meas_valid(meas_valid),
    .meas_coef(meas_coef),
    .tif(tif)
  );

  // ==========================================================
  // Load sequence and coefficient management
  always_comb begin
    st_next = st_reg;
    init_next = init_reg;
    mode_next = mode_reg;
    act_next = act_reg;
    once_next = once_reg;
    gain_next = gain_reg;
    coef_next = coef_reg;
    ucoef_next = ucoef_reg;
    held_next = held_reg;
    held_ok_next = held_ok_reg;
    en_prev_next = en_prev_reg;
    stb_next = 1'b0;
    smode_next = smode_reg;
    sonce_next = sonce_reg;
    sgain_next = sgain_reg;
    scoef_next = scoef_reg;
    unique case (st_reg)
      INIT_STRAP: begin
        mode_next = strap_s2_reg ? MODE_OFF : MODE_RST;
        gain_next = GAIN_RST;
        once_next = 1'b0;
        coef_next = SAFE_COEF;
        st_next = INIT_FACTORY;
      end
      INIT_FACTORY: begin
        if (factory_valid) begin
          mode_next = factory_mode;
          gain_next = clamp_gain(factory_gain);
          ucoef_next = factory_coef;
        end
        st_next = INIT_USER;
      end
      INIT_USER: begin
        if (user_valid) begin
          mode_next = user_mode;
          once_next = user_once;
          gain_next = clamp_gain(user_gain);
          ucoef_next = user_coef;
        end
        if (mode_on(fin_mode)) begin
          coef_next = SAFE_COEF;
        end else begin
          coef_next = user_valid ? user_coef : ucoef_reg;
        end
        act_next = fin_mode;
        en_prev_next = mode_on(fin_mode);
        // Status pin taken from its own flip-flop
        init_next = 1'b1;
        st_next = INIT_RUN;
      end
      INIT_RUN: begin
        if (host_mode_wr) begin
          mode_next = host_mode;
        end
        if (host_once_wr) begin
          once_next = host_once;
        end
        if (host_gain_wr) begin
          gain_next = clamp_gain(host_gain);
        end
        if (host_coef_wr) begin
          coef_next = host_coef_data;
        end
        if (oe_rise || tick) begin
          act_next = mode_reg;
        end
        en_prev_next = mode_on(mode_reg);
        if (mode_on(mode_reg) && !en_prev_reg) begin
          coef_next = SAFE_COEF;
        end
        if (!mode_on(mode_reg) && en_prev_reg) begin
          coef_next = ucoef_reg;
        end
        if (ramp_rise && act_reg == MODE_EACH_ENABLE && reuse) begin
          coef_next = held_reg;
        end
        if (tif.done && tif.ok) begin
          coef_next = tif.result;
          held_next = tif.result;
          held_ok_next = 1'b1;
        end
        if (host_store_user) begin
          stb_next = 1'b1;
          smode_next = mode_reg;
          sonce_next = once_reg;
          sgain_next = gain_reg;
          scoef_next = coef_reg;
          ucoef_next = coef_reg;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= INIT_STRAP;
      init_reg <= 1'b0;
      mode_reg <= MODE_RST;
      act_reg <= MODE_OFF;
      once_reg <= 1'b0;
      gain_reg <= GAIN_RST;
      coef_reg <= SAFE_COEF;
      ucoef_reg <= SAFE_COEF;
      held_reg <= SAFE_COEF;
      held_ok_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      stb_reg <= 1'b0;
      smode_reg <= MODE_RST;
      sonce_reg <= 1'b0;
      sgain_reg <= GAIN_RST;
      scoef_reg <= SAFE_COEF;
    end else begin
      st_reg <= st_next;
      init_reg <= init_next;
      mode_reg <= mode_next;
      act_reg <= act_next;
      once_reg <= once_next;
      gain_reg <= gain_next;
      coef_reg <= coef_next;
      ucoef_reg <= ucoef_next;
      held_reg <= held_next;
      held_ok_reg <= held_ok_next;
      en_prev_reg <= en_prev_next;
      busy_reg <= tif.busy;
      done_reg <= tif.done && tif.ok;
      stb_reg <= stb_next;
      smode_reg <= smode_next;
      sonce_reg <= sonce_next;
      sgain_reg <= sgain_next;
      scoef_reg <= scoef_next;
    end
  end

  // ==========================================================
  // Outputs
  assign coef_out = coef_reg;
  assign mode_out = mode_reg;
  assign once_out = once_reg;
  assign gain_out = gain_reg;
  assign init_done = init_reg;
  assign tune_busy = busy_reg;
  assign tune_done = done_reg;
  assign store_stb = stb_reg;
  assign store_mode = smode_reg;
  assign store_once = sonce_reg;
  assign store_gain = sgain_reg;
  assign store_coef = scoef_reg;

endmodule

// *** tb/lapm_checker.sv ***
`timescale 1ns/10ps
module lapm_checker
  import lapm_pkg::*;
#(
  parameter int unsigned TUNE_MAX_CYCLES = TUNE_MAX_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Host side and output enable
  input wire logic host_coef_wr,
  input wire logic [COEF_W-1:0] host_coef_data,
  input wire logic host_mode_wr,
  input wire logic host_gain_wr,
  input wire logic [GAIN_W-1:0] host_gain,
  input wire logic host_tune_trig,
  input wire logic host_store_user,
  input wire logic output_en,
  // Outputs
  input wire logic [COEF_W-1:0] coef_out,
  input wire lapm_mode_t mode_out,
  input wire logic [GAIN_W-1:0] gain_out,
  input wire logic init_done,
  input wire logic tune_busy,
  input wire logic tune_done,
  input wire logic store_stb,
  input wire logic [COEF_W-1:0] store_coef
);
  localparam int RUN_MAX = TUNE_MAX_CYCLES + 6;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Assertions
  reset_state_a: assert property (disable iff (1'b0)
    srst |=> coef_out == SAFE_COEF && mode_out == MODE_RST && gain_out == GAIN_RST && !init_done)
    else $error("reset values wrong");
  init_seq_a: assert property ($fell(srst) |-> !init_done ##[1:4] init_done)
    else $error("load sequence length wrong");
  done_pulse_a: assert property (tune_done |=> !tune_done)
    else $error("tune_done longer than one cycle");
  done_busy_a: assert property (tune_done |-> tune_busy)
    else $error("tune_done outside a run");
  run_min_a: assert property ($rose(tune_busy) |-> !tune_done [*3])
    else $error("run ended too soon");
  run_max_a: assert property ($rose(tune_busy) |-> ##[1:RUN_MAX] !tune_busy)
    else $error("run never ended");
  trig_start_a: assert property (init_done && host_tune_trig && !tune_busy
    && !$past(tune_busy) && !$past(tune_busy, 2) |-> ##2 tune_busy)
    else $error("trigger did not start run");
  coef_wr_a: assert property (init_done && host_coef_wr && !tune_busy && !output_en
    && !host_mode_wr && !$past(host_mode_wr) && !host_tune_trig && !$past(host_tune_trig)
    |=> coef_out == $past(host_coef_data))
    else $error("coefficient write lost");
  on_safe_a: assert property (init_done && $past(init_done) && !tune_busy
    && $past(mode_out) == MODE_OFF && mode_out != MODE_OFF |=> coef_out == SAFE_COEF)
    else $error("safe set not loaded");
  store_copy_a: assert property (init_done && host_store_user
    |=> store_stb && store_coef == $past(coef_out))
    else $error("store content wrong");
  gain_clamp_a: assert property (init_done && host_gain_wr |=> gain_out ==
    ($past(host_gain) < GAIN_MIN ? GAIN_MIN :
     $past(host_gain) > GAIN_FULL ? GAIN_FULL : $past(host_gain)))
    else $error("gain not clamped");
  run_c: cover property ($rose(tune_busy));
  done_c: cover property (tune_done);
  store_c: cover property (store_stb);
endmodule

// *** tb/lapm_host_model.sv ***
`timescale 1ns/10ps
module lapm_host_model
  import lapm_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Command strobes
  output logic host_coef_wr,
  output logic host_mode_wr,
  output logic host_once_wr,
  output logic host_gain_wr,
  output logic host_tune_trig,
  output logic host_store_user,
  // Command data
  output logic [COEF_W-1:0] host_coef_data,
  output lapm_mode_t host_mode,
  output logic host_once,
  output logic [GAIN_W-1:0] host_gain
);
  logic [5:0] wr;
  assign {host_store_user, host_tune_trig, host_gain_wr} = wr[5:3];
  assign {host_once_wr, host_mode_wr, host_coef_wr} = wr[2:0];
  initial begin
    wr = '0;
    host_coef_data = '0;
    host_mode = MODE_RST;
    host_once = 1'b0;
    host_gain = GAIN_RST;
  end
  // ==========================================================
  // Commands
  // settings and commands from host
  task automatic pulse(input int k);
    wr[k] = 1'b1;
    @(posedge ref_clk);
    #1;
    wr[k] = 1'b0;
    host_coef_data = ~host_coef_data;
  endtask
  task automatic set_mode(input lapm_mode_t m);
    @(posedge ref_clk);
    #1;
    host_mode = m;
    pulse(1);
  endtask
  task automatic set_once(input logic v);
    @(posedge ref_clk);
    #1;
    host_once = v;
    pulse(2);
  endtask
  task automatic set_gain(input logic [GAIN_W-1:0] g);
    @(posedge ref_clk);
    #1;
    host_gain = g;
    pulse(3);
  endtask
  task automatic wr_coef(input logic [COEF_W-1:0] c);
    @(posedge ref_clk);
    #1;
    host_coef_data = c;
    pulse(0);
  endtask
  task automatic trig();
    @(posedge ref_clk);
    #1;
    pulse(4);
  endtask
  task automatic store();
    @(posedge ref_clk);
    #1;
    pulse(5);
  endtask
endmodule

// *** tb/lapm_top_bench.sv ***
`timescale 1ns/10ps
module lapm_top_bench;
  import lapm_pkg::*;
  localparam int SEC = 20;
  logic ref_clk, srst, strap_tune_off, output_en, ramp_done, meas_valid;
  logic host_coef_wr, host_mode_wr, host_once_wr, host_once, host_gain_wr;
  logic host_tune_trig, host_store_user, factory_valid, user_valid, user_once;
  logic once_out, init_done, tune_busy, tune_done, store_stb, store_once;
  lapm_mode_t host_mode, factory_mode, user_mode, mode_out, store_mode;
  logic [GAIN_W-1:0] host_gain, factory_gain, user_gain, gain_out, store_gain;
  logic [COEF_W-1:0] host_coef_data, factory_coef, user_coef, meas_coef;
  logic [COEF_W-1:0] coef_out, store_coef, held, univ;
  logic [COEF_W-1:0] exp_q[$], sto_q[$];
  logic [GAIN_W-1:0] gl[5] = '{7'h0a, 7'h64, 7'h05, 7'h70, 7'h32};
  int ge[5] = '{10, 100, 10, 100, 50};
  lapm_mode_t pm[2] = '{MODE_EVERY_SEC, MODE_EVERY_MIN};
  int errors, check_count;

  lapm_top #(.SEC_CYCLES(SEC), .TUNE_MIN_CYCLES(5), .TUNE_MAX_CYCLES(20)) lapm_top_inst (
    .ref_clk, .srst, .host_coef_wr, .host_coef_data, .host_mode_wr, .host_mode,
    .host_once_wr, .host_once, .host_gain_wr, .host_gain, .host_tune_trig,
    .host_store_user, .strap_tune_off, .factory_valid, .factory_mode, .factory_gain,
    .factory_coef, .user_valid, .user_mode, .user_once, .user_gain, .user_coef,
    .output_en, .ramp_done, .meas_valid, .meas_coef, .coef_out, .mode_out, .once_out,
    .gain_out, .init_done, .tune_busy, .tune_done, .store_stb, .store_mode,
    .store_once, .store_gain, .store_coef);
  lapm_host_model lapm_host_model_inst (
    .ref_clk, .host_coef_wr, .host_mode_wr, .host_once_wr, .host_gain_wr,
    .host_tune_trig, .host_store_user, .host_coef_data, .host_mode, .host_once,
    .host_gain);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [COEF_W-1:0] exp_scale(input logic [COEF_W-1:0] c, input int g);
    logic [COEF_W-1:0] r;
    int t;
    r = '0;
    for (int i = 0; i < 3; i++) begin
      t = int'($signed(c[i*24 +: 24]));
      r[i*24 +: 24] = 24'((t * g) / 100);
    end
    return r;
  endfunction

  function automatic logic [COEF_W-1:0] rnd();
    return 72'({$urandom, $urandom, $urandom});
  endfunction

  task automatic check(input logic [COEF_W-1:0] got, input logic [COEF_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (tune_done !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    if (k >= lim) begin
      errors++;
      $display("ERROR %0t no tuning result", $time);
    end
    tick(3);
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Measurement engine and result monitor
  always @(posedge ref_clk) begin
    #1;
    meas_valid = tune_busy === 1'b1 && !meas_valid;
  end

  always @(negedge ref_clk) begin
    if (tune_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("ERROR %0t unexpected tuning result", $time);
      end else
        check(coef_out, exp_q.pop_front());
    end
    if (store_stb === 1'b1 && sto_q.size() > 0) begin
      check(store_coef, sto_q.pop_front());
    end
  end

  initial begin
    #300000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6301c5ce));
    errors = 0;
    check_count = 0;
    srst = 1'b1;
    strap_tune_off = 1'b0;
    output_en = 1'b0;
    ramp_done = 1'b0;
    meas_valid = 1'b0;
    meas_coef = rnd();
    factory_valid = 1'b1;
    factory_mode = MODE_EACH_ENABLE;
    factory_gain = GAIN_RST;
    factory_coef = rnd();
    user_valid = 1'b1;
    user_mode = MODE_EACH_ENABLE;
    user_once = 1'b0;
    user_gain = GAIN_RST;
    user_coef = rnd();
    univ = 72'h7cb941fdc3417ccd99;
    gl[4] = 7'(10 + $urandom_range(90));
    ge[4] = int'(gl[4]);
    tick(2);
    srst = 1'b0;
    tick(4);
    check(72'(init_done), 72'h1);
    check(coef_out, SAFE_COEF);
    output_en = 1'b1;
    tick(1);
    meas_coef = rnd();
    exp_q.push_back(exp_scale(meas_coef, 50));
    ramp_done = 1'b1;
    wait_done(40);
    held = coef_out;
    sto_q.push_back(held);
    lapm_host_model_inst.store();
    check(72'({store_mode, store_once, store_gain}),
          72'({MODE_EACH_ENABLE, 1'b0, GAIN_RST}));
    lapm_host_model_inst.set_mode(MODE_OFF);
    tick(1);
    check(coef_out, held);
    lapm_host_model_inst.wr_coef(univ);
    check(coef_out, univ);
    sto_q.push_back(univ);
    lapm_host_model_inst.store();
    lapm_host_model_inst.set_mode(MODE_EACH_ENABLE);
    tick(1);
    check(coef_out, SAFE_COEF);
    lapm_host_model_inst.set_mode(MODE_OFF);
    tick(1);
    check(coef_out, univ);
    foreach (gl[i]) begin
      lapm_host_model_inst.set_gain(gl[i]);
      meas_coef = rnd();
      exp_q.push_back(exp_scale(meas_coef, ge[i]));
      lapm_host_model_inst.trig();
      tick(1);
      lapm_host_model_inst.trig();
      wait_done(40);
    end
    tick(30);
    foreach (pm[i]) begin
      lapm_host_model_inst.set_mode(pm[i]);
      output_en = 1'b0;
      ramp_done = 1'b0;
      tick(2);
      meas_coef = rnd();
      exp_q.push_back(exp_scale(meas_coef, ge[4]));
      output_en = 1'b1;
      wait_done(SEC * 60 + 60);
      output_en = 1'b0;
    end
    srst = 1'b1;
    strap_tune_off = 1'b1;
    user_mode = MODE_OFF;
    user_coef = rnd();
    tick(4);
    srst = 1'b0;
    tick(4);
    check(coef_out, user_coef);
    check(72'(mode_out), 72'(MODE_OFF));
    lapm_host_model_inst.set_once(1'b1);
    check(72'(once_out), 72'h1);
    lapm_host_model_inst.set_mode(MODE_EACH_ENABLE);
    meas_coef = rnd();
    held = exp_scale(meas_coef, 50);
    exp_q.push_back(held);
    output_en = 1'b1;
    tick(1);
    ramp_done = 1'b1;
    wait_done(40);
    output_en = 1'b0;
    ramp_done = 1'b0;
    lapm_host_model_inst.wr_coef(univ);
    output_en = 1'b1;
    tick(1);
    ramp_done = 1'b1;
    tick(3);
    check(coef_out, held);
    check(72'(tune_busy), 72'h0);
    tick(10);
    wrap_up();
  end
endmodule

bind lapm_top lapm_checker #(.TUNE_MAX_CYCLES(TUNE_MAX_CYCLES)) lapm_checker_inst (
  .ref_clk, .srst, .host_coef_wr, .host_coef_data, .host_mode_wr, .host_gain_wr,
  .host_gain, .host_tune_trig, .host_store_user, .output_en, .coef_out, .mode_out,
  .gain_out, .init_done, .tune_busy, .tune_done, .store_stb, .store_coef);
